// file: hdl/gtsio_pkg.sv
/*
  gtsio_pkg: shared constants for the genlock, timing and shared-io block.
  assumes a 10 MHz ref_clk; video positions are counted in pixel steps of that clock.
*/
package gtsio_pkg;
  // ***********************************************************
  // register indices, reset values
  // ***********************************************************
  localparam logic [7:0] GTSIO_IDX_PORT_VALUE = 8'h0E;
  localparam logic [7:0] GTSIO_IDX_PORT_DIR = 8'h0F;
  localparam logic [7:0] GTSIO_PORT_RST = 8'h00;
  localparam logic [7:0] GTSIO_DIR_RST = 8'h00;
  // ***********************************************************
  // port bit positions
  // ***********************************************************
  localparam int GTSIO_BIT_CSYNC = 0;
  localparam int GTSIO_BIT_CLAMP = 1;
  localparam int GTSIO_BIT_HSYNC = 2;
  localparam int GTSIO_BIT_FIELD = 3;
  localparam int GTSIO_BIT_SCSYNC = 6;
  localparam int GTSIO_BIT_PALID = 7;
  // ***********************************************************
  // video standard codes, line timing
  // ***********************************************************
  localparam logic [1:0] GTSIO_STD_NTSC = 2'b00;
  localparam logic [1:0] GTSIO_STD_PAL_A = 2'b01;
  localparam logic [1:0] GTSIO_STD_PAL_B = 2'b10;
  localparam logic [10:0] GTSIO_LINE_LEN = 11'h6B4;
  localparam logic [10:0] GTSIO_PALID_WIN_LO = 11'h5A0;
  localparam logic [10:0] GTSIO_PALID_WIN_HI = 11'h5A9;
  localparam logic [10:0] GTSIO_HSYNC_LEN = 11'h07E;
  localparam logic [10:0] GTSIO_CLAMP_LO = 11'h090;
  localparam logic [10:0] GTSIO_CLAMP_HI = 11'h0A8;
  localparam logic [9:0] GTSIO_FIELD_LINES = 10'h106;
  localparam logic [2:0] GTSIO_FIELDS_RESET = 3'h7;
  localparam logic [1:0] GTSIO_QUAD_LAST = 2'h3;
  // ***********************************************************
  // ramp levels (ire)
  // ***********************************************************
  localparam logic [6:0] GTSIO_RAMP_BLANK_IRE = 7'h00;
  localparam logic [6:0] GTSIO_RAMP_WHITE_IRE = 7'h64;
  localparam logic [6:0] GTSIO_RAMP_CHROMA_IRE = 7'h28;
  typedef enum logic [1:0] {
    GTSIO_FREE = 2'b00,
    GTSIO_LOCK = 2'b01,
    GTSIO_SLAVE = 2'b11
  } gtsio_mode_t;
endpackage

// file: hdl/gtsio_sync2.sv
/*
  gtsio_sync2: two-flop synchroniser for a bus of pin inputs.
  assumes the inputs are asynchronous levels.
*/
`timescale 1ns/1ns
module gtsio_sync2 #(
  parameter int W = 8
) (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // async reset
  input wire logic [W-1:0] d, // async levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_q;
  // ***********************************************************
  // first flop read only by the second
  // ***********************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: hdl/gtsio_top.sv
/*
  gtsio_top: genlock input handling, sch phase, timing mode, shared port pins, ramp.
  assumes host control bits arrive as plain ports on ref_clk; pins are asynchronous.
*/
`timescale 1ns/1ns
module gtsio_top (
  input wire logic ref_clk, // pixel clock
  input wire logic rst_n, // async reset, active low
  input wire logic genlock_enable, // analog genlock on
  input wire logic ref_quad_rate_select, // reference is four times fsc
  input wire logic [1:0] video_standard, // 00 ntsc, 01/10 pal
  input wire logic master_mode, // master timing selected by host
  input wire logic [15:0] sch_offset, // {sch_offset_high, sch_offset_low}
  input wire logic composite_sync_disable, // pin 0 plain gpio when set
  input wire logic clamp_gate_disable, // pin 1 plain gpio when set
  input wire logic test_ramp_enable, // ramp generator on
  input wire logic pedestal_enable, // ramp needs this low
  input wire logic composite_dac_off, // composite dac power down
  input wire logic svideo_dac_off, // luma/chroma dacs power down
  input wire logic subcarrier_reference_in, // reference square wave pin
  input wire logic eav_seen, // eav decoded this cycle (same clock)
  input wire logic eav_field, // f bit of that eav
  input wire logic eav_vblank, // v bit of that eav
  input wire logic port_wr, // port write strobe
  input wire logic [7:0] port_wr_idx, // register index written
  input wire logic [7:0] port_wr_data, // write data
  input wire logic [7:0] port_pin_in, // pin levels
  output logic [7:0] port_pin_out, // pin drive values
  output logic [7:0] port_pin_oe, // pin drive enables, high drives
  output logic [7:0] port_value, // port value register read
  output logic [7:0] port_dir, // port direction register read
  output logic [15:0] subcarrier_phase, // synthesizer reset phase with offset
  output logic synth_phase_reset, // one-cycle synthesizer reset pulse
  output logic chroma_v_invert, // v axis inverted on this line
  output logic line_blank, // current line blanked
  output logic even_field, // current field is even
  output logic [6:0] ramp_luma_ire, // ramp luma level
  output logic [6:0] ramp_chroma_ire, // ramp chroma amplitude
  output logic ramp_active, // ramp really running
  output logic composite_dac_pd, // composite dac powered down
  output logic svideo_dac_pd, // s-video dacs powered down
  output logic [1:0] ref_phase // reference divider count
);
  import gtsio_pkg::*;

  logic [7:0] pin_s;
  logic ref_s;
  logic [7:0] value_q, value_d;
  logic [7:0] dir_q;
  logic [1:0] div_q;
  logic ref_d1_q;
  logic scsync_d1_q;
  logic [10:0] pix_q;
  logic [9:0] line_q;
  logic [2:0] field_cnt_q;
  logic palid_smp_q;
  logic vinv_q;
  logic hsync_q, field_q, csync_q, clamp_q;
  logic blank_q;
  logic [15:0] phase_q;
  logic pulse_q;
  logic [6:0] luma_q;
  gtsio_mode_t mode;

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  gtsio_sync2 #(.W(9)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({subcarrier_reference_in, port_pin_in}),
    .q({ref_s, pin_s})
  );

  // ***********************************************************
  // pin function selection
  // ***********************************************************
  // decoding kept as named wires so the checker can see the muxing
  wire is_pal = (video_standard == GTSIO_STD_PAL_A) || (video_standard == GTSIO_STD_PAL_B);
  wire scsync_sel = !dir_q[GTSIO_BIT_SCSYNC] && genlock_enable && ref_quad_rate_select;
  wire palid_sel = !dir_q[GTSIO_BIT_PALID] && genlock_enable && is_pal;
  wire master_pins = master_mode && dir_q[GTSIO_BIT_HSYNC] && dir_q[GTSIO_BIT_FIELD];
  wire csync_sel = dir_q[GTSIO_BIT_CSYNC] && !composite_sync_disable;
  wire clamp_sel = dir_q[GTSIO_BIT_CLAMP] && !clamp_gate_disable;
  wire scsync_pin = pin_s[GTSIO_BIT_SCSYNC];
  wire scsync_rise = scsync_sel && scsync_pin && !scsync_d1_q;
  wire ref_rise = ref_s && !ref_d1_q;
  wire line_end = (pix_q == GTSIO_LINE_LEN - 11'h001);
  wire field_end = line_end && (line_q == GTSIO_FIELD_LINES - 10'h001);
  wire palid_win = (pix_q >= GTSIO_PALID_WIN_LO) && (pix_q <= GTSIO_PALID_WIN_HI);
  wire ramp_on = test_ramp_enable && !pedestal_enable;
  wire wr_value = port_wr && (port_wr_idx == GTSIO_IDX_PORT_VALUE);
  wire wr_dir = port_wr && (port_wr_idx == GTSIO_IDX_PORT_DIR);

  assign mode = master_mode ? GTSIO_FREE : (genlock_enable ? GTSIO_LOCK : GTSIO_SLAVE);

  // writes land only on bits that drive a plain output; the others keep their value
  function automatic logic [7:0] writable(input logic [7:0] dir, input logic cs, input logic cl,
                                          input logic mp);
    logic [7:0] m;
    m = dir;
    m[GTSIO_BIT_CSYNC] = dir[GTSIO_BIT_CSYNC] && cs;
    m[GTSIO_BIT_CLAMP] = dir[GTSIO_BIT_CLAMP] && cl;
    m[GTSIO_BIT_HSYNC] = dir[GTSIO_BIT_HSYNC] && !mp;
    m[GTSIO_BIT_FIELD] = dir[GTSIO_BIT_FIELD] && !mp;
    return m;
  endfunction

  wire [7:0] wmask = writable(dir_q, composite_sync_disable, clamp_gate_disable, master_pins);
  assign value_d = wr_value ? ((value_q & ~wmask) | (port_wr_data & wmask)) : value_q;

  // ***********************************************************
  // port registers
  // ***********************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= GTSIO_PORT_RST;
      dir_q <= GTSIO_DIR_RST;
    end else begin
      value_q <= value_d;
      if (wr_dir) begin
        dir_q <= port_wr_data;
      end
    end
  end

  // inputs read the pin; outputs read back the stored bit (reads there are loosely defined)
  assign port_value = (dir_q & value_q) | (~dir_q & pin_s);
  assign port_dir = dir_q;

  // ***********************************************************
  // pin drive
  // ***********************************************************
  // all enables follow the direction register, which clears on reset: pins float
  always_comb begin
    port_pin_oe = dir_q;
    port_pin_out = value_q;
    port_pin_out[GTSIO_BIT_CSYNC] = csync_sel ? csync_q : value_q[GTSIO_BIT_CSYNC];
    port_pin_out[GTSIO_BIT_CLAMP] = clamp_sel ? clamp_q : value_q[GTSIO_BIT_CLAMP];
    if (master_pins) begin
      port_pin_out[GTSIO_BIT_HSYNC] = hsync_q;
      port_pin_out[GTSIO_BIT_FIELD] = field_q;
    end
  end

  // ***********************************************************
  // reference divider
  // ***********************************************************
  // sync edge wins over a reference edge in the same cycle; at fsc rate the divider idles at zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'h0;
      ref_d1_q <= 1'b0;
      scsync_d1_q <= 1'b0;
    end else begin
      ref_d1_q <= ref_s;
      scsync_d1_q <= scsync_pin;
      if (scsync_rise) begin
        div_q <= 2'h0;
      end else if (!ref_quad_rate_select) begin
        div_q <= 2'h0;
      end else if (ref_rise) begin
        div_q <= (div_q == GTSIO_QUAD_LAST) ? 2'h0 : div_q + 2'h1;
      end
    end
  end
  assign ref_phase = div_q;

  // ***********************************************************
  // line and field timing
  // ***********************************************************
  // slave mode realigns to each eav; master (free run) and genlock modes count on their own
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_q <= 11'h000;
      line_q <= 10'h000;
      field_q <= 1'b0;
      blank_q <= 1'b0;
    end else if (mode == GTSIO_SLAVE && eav_seen) begin
      pix_q <= 11'h000;
      blank_q <= eav_vblank;
      if (eav_field != field_q) begin
        line_q <= 10'h000;
      end else begin
        line_q <= line_q + 10'h001;
      end
      field_q <= eav_field;
    end else if (line_end) begin
      pix_q <= 11'h000;
      line_q <= field_end ? 10'h000 : line_q + 10'h001;
      if (field_end && mode != GTSIO_SLAVE) begin
        field_q <= !field_q;
      end
    end else begin
      pix_q <= pix_q + 11'h001;
    end
  end
  assign line_blank = blank_q;
  assign even_field = field_q;

  // ***********************************************************
  // timing outputs
  // ***********************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hsync_q <= 1'b0;
      csync_q <= 1'b0;
      clamp_q <= 1'b0;
    end else begin
      hsync_q <= (pix_q < GTSIO_HSYNC_LEN);
      csync_q <= (pix_q < GTSIO_HSYNC_LEN) || blank_q;
      clamp_q <= (pix_q >= GTSIO_CLAMP_LO) && (pix_q < GTSIO_CLAMP_HI);
    end
  end

  // ***********************************************************
  // pal line phase
  // ***********************************************************
  // sampled late in the window, applied only from the next line start
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      palid_smp_q <= 1'b0;
      vinv_q <= 1'b0;
    end else begin
      if (palid_win && pix_q == GTSIO_PALID_WIN_HI) begin
        palid_smp_q <= pin_s[GTSIO_BIT_PALID];
      end
      if (line_end) begin
        vinv_q <= palid_sel && palid_smp_q;
      end
    end
  end
  assign chroma_v_invert = vinv_q;

  // ***********************************************************
  // sch phase and eight-field reset
  // ***********************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      field_cnt_q <= 3'h0;
      pulse_q <= 1'b0;
      phase_q <= 16'h0000;
    end else begin
      phase_q <= sch_offset;
      pulse_q <= 1'b0;
      if (field_end && mode == GTSIO_FREE) begin
        field_cnt_q <= field_cnt_q + 3'h1;
        pulse_q <= (field_cnt_q == GTSIO_FIELDS_RESET);
      end
    end
  end
  assign subcarrier_phase = phase_q;
  assign synth_phase_reset = pulse_q;

  // ***********************************************************
  // test ramp
  // ***********************************************************
  // one luma step per pixel, clipped at white; coarse but enough for dg/dp checks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      luma_q <= GTSIO_RAMP_BLANK_IRE;
    end else if (!ramp_on || line_end) begin
      luma_q <= GTSIO_RAMP_BLANK_IRE;
    end else if (luma_q < GTSIO_RAMP_WHITE_IRE) begin
      luma_q <= luma_q + 7'h01;
    end
  end
  assign ramp_luma_ire = luma_q;
  assign ramp_chroma_ire = ramp_on ? GTSIO_RAMP_CHROMA_IRE : 7'h00;
  assign ramp_active = ramp_on;

  // ***********************************************************
  // dac power
  // ***********************************************************
  assign composite_dac_pd = composite_dac_off || !rst_n;
  assign svideo_dac_pd = svideo_dac_off || !rst_n;
endmodule

// file: verif/gtsio_pin_model.sv
/*
  gtsio_pin_model: far side of the shared port pins and the reference source.
  assumes the bench sets the external levels and starts or stops the reference.
*/
`timescale 1ns/1ns
module gtsio_pin_model (
  input wire logic ref_clk, // pixel clock
  input wire logic ref_run, // reference square wave running
  input wire logic [7:0] pin_ext, // levels the outside world applies
  input wire logic [7:0] port_pin_out, // block drive values
  input wire logic [7:0] port_pin_oe, // block drive enables
  output logic [7:0] port_pin_in, // resolved pin levels
  output logic subcarrier_reference_in // reference square wave
);
  // ***********************************************************
  // wire resolution and reference
  // ***********************************************************
  logic [1:0] div_q = 2'h0;
  // a driven pin shows the block's value, otherwise the outside level
  assign port_pin_in = (port_pin_oe & port_pin_out) | (~port_pin_oe & pin_ext);
  // square wave at a quarter of the clock rate; it stands still while stopped
  always @(posedge ref_clk) begin
    if (ref_run) begin
      div_q <= div_q + 2'h1;
    end
  end
  assign subcarrier_reference_in = div_q[1];
endmodule

// file: verif/gtsio_asserts.sv
/*
  gtsio_asserts: port-level checks for gtsio_top.
  assumes one clock domain, ref_clk, with rst_n as asynchronous reset.
*/
`timescale 1ns/1ns
module gtsio_asserts
  import gtsio_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic genlock_enable, // genlock on
  input wire logic ref_quad_rate_select, // quad reference
  input wire logic test_ramp_enable, // ramp on
  input wire logic pedestal_enable, // pedestal
  input wire logic composite_dac_off, // dac off
  input wire logic svideo_dac_off, // dac off
  input wire logic port_wr, // write strobe
  input wire logic [7:0] port_wr_idx, // write index
  input wire logic [7:0] port_wr_data, // write data
  input wire logic [7:0] port_pin_in, // pins
  input wire logic [7:0] port_pin_out, // pin drive
  input wire logic [7:0] port_pin_oe, // pin enables
  input wire logic [7:0] port_value, // value read
  input wire logic [7:0] port_dir, // direction read
  input wire logic synth_phase_reset, // synth reset pulse
  input wire logic chroma_v_invert, // v invert
  input wire logic [6:0] ramp_luma_ire, // luma
  input wire logic [6:0] ramp_chroma_ire, // chroma
  input wire logic ramp_active, // ramp running
  input wire logic composite_dac_pd, // pd
  input wire logic svideo_dac_pd, // pd
  input wire logic [1:0] ref_phase // divider
);
  // ***********************************************************
  // properties
  // ***********************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_dir_write;
    port_wr && port_wr_idx == GTSIO_IDX_PORT_DIR;
  endsequence
  sequence s_quad_off;
    !ref_quad_rate_select [*2];
  endsequence
  // reset is checked while it is held, so its own disable is switched off
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> composite_dac_pd && svideo_dac_pd && port_pin_oe == 8'h00) else $error("outputs active in reset");
  a_dir_write: assert property (s_dir_write |=> port_dir == $past(port_wr_data)) else $error("direction write lost");
  a_oe_is_dir: assert property (port_pin_oe == port_dir) else $error("enable differs from direction");
  a_pin_drive: assert property (port_dir[5] |-> port_pin_out[5] == port_value[5]) else $error("pin 5 drive wrong");
  a_pin_read: assert property ($past(rst_n, 2) && !port_dir[4] |-> port_value[4] == $past(port_pin_in[4], 2)) else $error("pin 4 read wrong");
  a_dac_indep: assert property (composite_dac_pd == composite_dac_off && svideo_dac_pd == svideo_dac_off) else $error("dac power wrong");
  a_ramp_levels: assert property (ramp_chroma_ire == (ramp_active ? GTSIO_RAMP_CHROMA_IRE : 7'h00) && ramp_luma_ire <= GTSIO_RAMP_WHITE_IRE) else $error("ramp level wrong");
  a_ramp_gate: assert property (ramp_active == (test_ramp_enable && !pedestal_enable)) else $error("ramp gate wrong");
  a_div_idle: assert property (s_quad_off |-> ref_phase == 2'h0) else $error("divider moved");
  a_pal_ignored: assert property (!genlock_enable [*2] |-> !$rose(chroma_v_invert)) else $error("pal phase honoured");
  a_synth_pulse: assert property (synth_phase_reset |=> !synth_phase_reset) else $error("synth reset too long");
endmodule
bind gtsio_top gtsio_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .genlock_enable(genlock_enable),
  .ref_quad_rate_select(ref_quad_rate_select), .test_ramp_enable(test_ramp_enable),
  .pedestal_enable(pedestal_enable), .composite_dac_off(composite_dac_off),
  .svideo_dac_off(svideo_dac_off), .port_wr(port_wr), .port_wr_idx(port_wr_idx),
  .port_wr_data(port_wr_data), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
  .port_pin_oe(port_pin_oe), .port_value(port_value), .port_dir(port_dir),
  .synth_phase_reset(synth_phase_reset), .chroma_v_invert(chroma_v_invert),
  .ramp_luma_ire(ramp_luma_ire), .ramp_chroma_ire(ramp_chroma_ire), .ramp_active(ramp_active),
  .composite_dac_pd(composite_dac_pd), .svideo_dac_pd(svideo_dac_pd), .ref_phase(ref_phase));

// file: verif/tb_top.sv
/*
  tb_top: self-checking bench for gtsio_top with the pin model on the far side.
  assumes 10 MHz ref_clk; inputs change 10 ns after each rising edge.
*/
`timescale 1ns/1ns
module tb_top;
  import gtsio_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b1, ref_run = 1'b0, gl = 1'b0, quad = 1'b0, mm = 1'b0;
  logic csd = 1'b1, cld = 1'b1, ramp = 1'b0, ped = 1'b0, cdo = 1'b0, sdo = 1'b0;
  logic eav = 1'b0, wr = 1'b0, efld = 1'b0, evb = 1'b0, evn, lblk;
  logic [15:0] sch = 16'h0000, sphase;
  logic [1:0] std = 2'b00, rph;
  logic [7:0] idx = 8'h00, wdat = 8'h00, pin_ext = 8'h00, pin_in, pout, poe, pval, pdir;
  logic [6:0] luma, chroma;
  logic ref_in, vinv, ract, cpd, spd;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  always #50 ref_clk = ~ref_clk;
  gtsio_pin_model u_pins (.ref_clk(ref_clk), .ref_run(ref_run), .pin_ext(pin_ext),
    .port_pin_out(pout), .port_pin_oe(poe), .port_pin_in(pin_in), .subcarrier_reference_in(ref_in));
  gtsio_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .genlock_enable(gl), .ref_quad_rate_select(quad),
    .video_standard(std), .master_mode(mm), .sch_offset(sch), .composite_sync_disable(csd),
    .clamp_gate_disable(cld), .test_ramp_enable(ramp), .pedestal_enable(ped),
    .composite_dac_off(cdo), .svideo_dac_off(sdo), .subcarrier_reference_in(ref_in),
    .eav_seen(eav), .eav_field(efld), .eav_vblank(evb), .port_wr(wr), .port_wr_idx(idx),
    .port_wr_data(wdat), .port_pin_in(pin_in), .port_pin_out(pout), .port_pin_oe(poe),
    .port_value(pval), .port_dir(pdir), .subcarrier_phase(sphase), .synth_phase_reset(),
    .chroma_v_invert(vinv), .line_blank(lblk), .even_field(evn), .ramp_luma_ire(luma),
    .ramp_chroma_ire(chroma), .ramp_active(ract), .composite_dac_pd(cpd), .svideo_dac_pd(spd),
    .ref_phase(rph));
  // ***********************************************************
  // helpers
  // ***********************************************************
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge ref_clk);
      #10;
    end
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one write strobe; it then stays low for one edge so back-to-back calls never merge
  task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
    wr = 1'b1;
    idx = i;
    wdat = d;
    tick();
    wr = 1'b0;
    tick();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_reset();
    chk("oe in reset", poe, 8'h00);
    chk("pd in reset", {6'h00, cpd, spd}, 8'h03);
    rst_n = 1'b1;
    tick(3);
    wr_reg(8'h10, 8'h00);
    chk("dir after reset", pdir, GTSIO_DIR_RST);
    chk("value after reset", pval, GTSIO_PORT_RST);
    $display("test reset done");
  endtask
  task automatic t_gpio();
    wr_reg(GTSIO_IDX_PORT_DIR, 8'h30);
    wr_reg(GTSIO_IDX_PORT_VALUE, 8'h20);
    tick();
    chk("pins 5 4 drive", {6'h00, pout[5:4]}, 8'h02);
    chk("pins 5 4 enable", poe, 8'h30);
    wr_reg(GTSIO_IDX_PORT_DIR, 8'h00);
    pin_ext = 8'h10;
    tick(3);
    chk("pin 4 read", {7'h00, pval[4]}, 8'h01);
    pin_ext = 8'h00;
    $display("test gpio done");
  endtask
  // pins 0 and 1: written bit as plain output, writes refused as special output
  task automatic t_special();
    int n0 = 0;
    int n1 = 0;
    wr_reg(GTSIO_IDX_PORT_DIR, 8'h03);
    wr_reg(GTSIO_IDX_PORT_VALUE, 8'h03);
    tick();
    chk("pins 1 0 gpio out", {6'h00, pout[1:0]}, 8'h03);
    csd = 1'b0;
    cld = 1'b0;
    wr_reg(GTSIO_IDX_PORT_VALUE, 8'h00);
    tick();
    chk("pins 1 0 stored kept", {6'h00, pval[1:0]}, 8'h03);
    // any window of one line length holds one line's worth of sync and clamp cycles
    repeat (GTSIO_LINE_LEN) begin
      tick();
      n0 += pout[0];
      n1 += pout[1];
    end
    chk("csync cycles", n0[15:0], {5'h00, GTSIO_HSYNC_LEN});
    chk("clamp cycles", n1[15:0], {5'h00, GTSIO_CLAMP_HI - GTSIO_CLAMP_LO});
    csd = 1'b1;
    cld = 1'b1;
    wr_reg(GTSIO_IDX_PORT_DIR, 8'h00);
    $display("test special pins done");
  endtask
  task automatic t_dac();
    for (int i = 0; i < 4; i++) begin
      {cdo, sdo} = i[1:0];
      tick();
      chk("dac pd", {6'h00, cpd, spd}, {6'h00, i[1:0]});
    end
    {cdo, sdo} = 2'b00;
    $display("test dac done");
  endtask
  task automatic t_ramp();
    wr_reg(8'h11, 8'h00);
    ramp = 1'b1;
    tick(2);
    chk("ramp chroma", {1'b0, chroma}, {1'b0, GTSIO_RAMP_CHROMA_IRE});
    for (int i = 0; i < 2000 && luma !== GTSIO_RAMP_WHITE_IRE; i++) tick();
    chk("ramp white", {9'h000, luma}, {9'h000, GTSIO_RAMP_WHITE_IRE});
    ped = 1'b1;
    tick();
    chk("ramp off with pedestal", {7'h00, ract}, 8'h00);
    chk("ramp blank", {9'h000, luma}, {9'h000, GTSIO_RAMP_BLANK_IRE});
    ramp = 1'b0;
    ped = 1'b0;
    $display("test ramp done");
  endtask
  // divider zeroed by the sync pin while the reference stands still
  task automatic t_divider();
    quad = 1'b1;
    ref_run = 1'b1;
    gl = 1'b1; // genlock enable goes last, after the rest of the setup
    for (int i = 0; i < 200 && rph === 2'h0; i++) tick();
    ref_run = 1'b0;
    tick(4);
    chk("divider counted", {7'h00, rph !== 2'h0}, 8'h01);
    pin_ext[6] = 1'b1;
    tick(5);
    chk("divider zero", {6'h00, rph}, 8'h00);
    pin_ext[6] = 1'b0;
    quad = 1'b0;
    $display("test divider done");
  endtask
  task automatic t_pal();
    std = GTSIO_STD_PAL_A;
    pin_ext[7] = 1'b1;
    for (int i = 0; i < 4000 && vinv !== 1'b1; i++) tick();
    chk("v invert on high", {7'h00, vinv}, 8'h01);
    // loops leave just after a line start, so the pin moves clear of the sample window
    pin_ext[7] = 1'b0;
    tick(1500);
    chk("v invert held to line end", {7'h00, vinv}, 8'h01);
    for (int i = 0; i < 4000 && vinv !== 1'b0; i++) tick();
    chk("v invert off on low", {7'h00, vinv}, 8'h00);
    std = GTSIO_STD_NTSC;
    pin_ext[7] = 1'b1;
    tick(4000);
    chk("pal phase ignored", {7'h00, vinv}, 8'h00);
    gl = 1'b0;
    $display("test pal done");
  endtask
  // master pins: hsync on pin 2, field on pin 3, port writes there refused
  task automatic t_master();
    int nh = 0;
    wr_reg(GTSIO_IDX_PORT_DIR, 8'h0C);
    mm = 1'b1; // stands for the reserved-register write
    sch = 16'hA5C3;
    wr_reg(GTSIO_IDX_PORT_VALUE, 8'h0C);
    repeat (GTSIO_LINE_LEN) begin
      tick();
      nh += pout[2];
    end
    chk("hsync cycles", nh[15:0], {5'h00, GTSIO_HSYNC_LEN});
    chk("field pin odd", {7'h00, pout[3]}, 8'h00);
    chk("sch phase master", sphase, sch);
    mm = 1'b0;
    tick();
    chk("pins 3 2 write refused", {6'h00, pout[3:2]}, 8'h00);
    wr_reg(GTSIO_IDX_PORT_DIR, 8'h00);
    $display("test master done");
  endtask
  // slave timing follows the eav field and blank bits
  task automatic t_slave();
    sch = 16'h5A3C;
    eav = 1'b1;
    efld = 1'b1;
    evb = 1'b1;
    tick();
    eav = 1'b0;
    tick();
    chk("eav field set", {7'h00, evn}, 8'h01);
    chk("eav blank set", {7'h00, lblk}, 8'h01);
    chk("sch phase slave", sphase, sch);
    eav = 1'b1;
    efld = 1'b0;
    evb = 1'b0;
    tick();
    eav = 1'b0;
    tick();
    chk("eav field clear", {7'h00, evn}, 8'h00);
    chk("eav blank clear", {7'h00, lblk}, 8'h00);
    $display("test slave done");
  endtask
  // reset falls after time zero so the flops see a real edge before the first clock
  initial begin
    #10;
    rst_n = 1'b0;
    tick(20);
    t_reset();
    t_gpio();
    t_special();
    t_master();
    t_dac();
    t_ramp();
    t_divider();
    t_pal();
    t_slave();
    complete_run();
  end
endmodule
